// ==== core/motor_ctl.sv ====
// Start/stop and fault control logic of a motor management relay, APB slave.
// Assumes all field inputs are already synchronous to i_clk and debounced.
`timescale 1ns/100ps
module motor_ctl (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [motor_ctl_pkg::APB_AW-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	// Field inputs
	input wire logic [motor_ctl_pkg::LI_COUNT-1:0] i_logic_in,
	input wire logic i_key_aux1,
	input wire logic i_key_aux2,
	input wire logic i_key_stop,
	input wire logic i_fault_det,
	input wire logic i_diag_err,
	input wire logic i_warn_det,
	input wire logic i_ctrl_volt_low,
	// Relay outputs, 1 = contact closed
	output logic o_run1,
	output logic o_run2,
	output logic o_warn,
	output logic o_fault_relay
);
	import motor_ctl_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic addr_is(input logic [APB_AW-1:0] a, input logic [7:0] off);
		addr_is = (a == off);
	endfunction

	function automatic logic addr_known(input logic [APB_AW-1:0] a);
		addr_known = addr_is(a, ADDR_CTRL) | addr_is(a, ADDR_CMD) | addr_is(a, ADDR_STATUS) | addr_is(a, ADDR_MEM);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [CTRL_W-1:0] ctrl_r;
	logic [CMD_W-1:0] cmd_r;
	logic mem_r;
	logic mem_nxt;
	logic fault_r;
	logic fault_nxt;
	logic latch1_r;
	logic latch1_nxt;
	logic latch2_r;
	logic latch2_nxt;
	logic [LI_COUNT-1:0] in_r;
	logic [LI_COUNT-1:0] in_prev_r;
	logic [2:0] key_r;
	logic [2:0] key_prev_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic mode_prev_r;
	logic run1_r;
	logic run2_r;
	logic warn_r;
	logic fault_relay_r;

	logic wr_acc;
	logic rd_setup;
	logic sw_reset;
	logic [LI_COUNT-1:0] in_rise;
	logic [2:0] key_rise;
	mode_t mode;
	channel_t channel;
	logic wire3;
	logic start1_lvl;
	logic start2_lvl;
	logic start1_rise;
	logic start2_rise;
	logic stop_ok;
	logic stop_key_hold;
	logic diag_fault;
	logic reset_cmd;
	logic run1_nxt;
	logic run2_nxt;
	logic [31:0] status_word;

	////////////////////////////////////////////////////////////////////////////////
	// Input sampling and edge detection

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			in_r <= '0;
			in_prev_r <= '0;
			key_r <= 3'h0;
			key_prev_r <= 3'h0;
		end else begin
			in_r <= i_logic_in;
			in_prev_r <= in_r;
			key_r <= {i_key_stop, i_key_aux2, i_key_aux1};
			key_prev_r <= key_r;
		end
	end

	// Resetting both samples to zero means an input already high at release reads as one edge
	assign in_rise = in_r & ~in_prev_r;
	assign key_rise = key_r & ~key_prev_r;

	////////////////////////////////////////////////////////////////////////////////
	// Channel selection and start/stop sources

	assign mode = ctrl_r[CTRL_MODE_BIT] ? MODE_INDEPENDENT : MODE_OVERLOAD;
	assign wire3 = ctrl_r[CTRL_WIRE3_BIT];

	always_comb begin
		if (in_r[LI_REMOTE]) begin
			channel = CH_NETWORK;
		end else if (ctrl_r[CTRL_HMI_BIT]) begin
			channel = CH_HMI;
		end else begin
			channel = CH_TERMINAL;
		end
	end

	always_comb begin
		start1_lvl = 1'b0;
		start2_lvl = 1'b0;
		start1_rise = 1'b0;
		start2_rise = 1'b0;
		stop_ok = 1'b1;
		stop_key_hold = 1'b0;
		case (channel)
			CH_TERMINAL: begin
				start1_lvl = in_r[LI_START1];
				start2_lvl = in_r[LI_START2];
				start1_rise = in_rise[LI_START1];
				start2_rise = in_rise[LI_START2];
				// With the terminal stop disabled the fault contact must break the coil instead
				stop_ok = ~ctrl_r[CTRL_STOPEN_BIT] | in_r[LI_STOP];
			end
			CH_HMI: begin
				start1_lvl = key_r[0];
				start2_lvl = key_r[1];
				start1_rise = key_rise[0];
				start2_rise = key_rise[1];
				stop_ok = ~key_r[2];
				stop_key_hold = key_r[2];
			end
			default: begin
				// Network commands act as maintained commands whatever the wiring type
				start1_lvl = cmd_r[CMD_FWD_BIT];
				start2_lvl = cmd_r[CMD_OUT23_BIT];
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fault handling

	assign diag_fault = i_diag_err & ((mode == MODE_INDEPENDENT) | ctrl_r[CTRL_DIAGEN_BIT]);
	assign reset_cmd = in_rise[LI_RESET] | sw_reset;

	always_comb begin
		fault_nxt = fault_r;
		if (i_fault_det | diag_fault) begin
			fault_nxt = 1'b1;
		end else if (reset_cmd) begin
			fault_nxt = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			fault_r <= 1'b0;
		end else begin
			fault_r <= fault_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Impulse latches

	always_comb begin
		latch1_nxt = latch1_r;
		latch2_nxt = latch2_r;
		if (!wire3 || mode != MODE_INDEPENDENT || channel == CH_NETWORK || mode_prev_r != ctrl_r[CTRL_MODE_BIT]) begin
			latch1_nxt = 1'b0;
			latch2_nxt = 1'b0;
		end else if (!stop_ok || fault_r || i_ctrl_volt_low) begin
			latch1_nxt = 1'b0;
			latch2_nxt = 1'b0;
		end else begin
			if (start1_rise) begin
				latch1_nxt = 1'b1;
			end
			// Input two may only close output two; opening is left to the stop
			if (start2_rise) begin
				latch2_nxt = 1'b1;
			end
		end
		if (diag_fault) begin
			latch1_nxt = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			latch1_r <= 1'b0;
			latch2_r <= 1'b0;
			mode_prev_r <= 1'b0;
		end else begin
			latch1_r <= latch1_nxt;
			latch2_r <= latch2_nxt;
			mode_prev_r <= ctrl_r[CTRL_MODE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Relay outputs

	always_comb begin
		run1_nxt = 1'b0;
		run2_nxt = 1'b0;
		case (mode)
			MODE_OVERLOAD: begin
				run1_nxt = cmd_r[CMD_FWD_BIT];
				run2_nxt = cmd_r[CMD_OUT23_BIT];
			end
			MODE_INDEPENDENT: begin
				// Each output decided on its own sources only
				if (wire3 && channel != CH_NETWORK) begin
					run1_nxt = latch1_nxt;
					run2_nxt = latch2_nxt;
				end else begin
					run1_nxt = start1_lvl & ~stop_key_hold;
					run2_nxt = start2_lvl & ~stop_key_hold;
				end
				if (i_ctrl_volt_low) begin
					run1_nxt = 1'b0;
					run2_nxt = 1'b0;
				end
				if (diag_fault) begin
					run1_nxt = 1'b0;
				end
			end
			default: begin
				run1_nxt = 1'b0;
				run2_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			run1_r <= 1'b0;
			run2_r <= 1'b0;
			warn_r <= 1'b0;
			fault_relay_r <= 1'b0;
		end else begin
			run1_r <= run1_nxt;
			run2_r <= run2_nxt;
			warn_r <= (mode == MODE_OVERLOAD) ? cmd_r[CMD_WARN_BIT] : i_warn_det;
			// Contact is held open with no supply as well as on a fault
			fault_relay_r <= ~fault_nxt & ~i_ctrl_volt_low;
		end
	end

	assign o_run1 = run1_r;
	assign o_run2 = run2_r;
	assign o_warn = warn_r;
	assign o_fault_relay = fault_relay_r;

	////////////////////////////////////////////////////////////////////////////////
	// Memory bit from the free third input

	always_comb begin
		mem_nxt = mem_r;
		if (wr_acc && addr_is(i_paddr, ADDR_MEM) && i_pstrb[0] && i_pwdata[0]) begin
			mem_nxt = 1'b0;
		end
		// A set in the clearing cycle wins
		if (ctrl_r[CTRL_I3MEM_BIT] && in_r[LI_FREE3]) begin
			mem_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			mem_r <= 1'b0;
		end else begin
			mem_r <= mem_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB register file

	assign wr_acc = i_psel & i_penable & i_pwrite;
	assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
	assign sw_reset = wr_acc & addr_is(i_paddr, ADDR_CMD) & i_pstrb[0] & i_pwdata[CMD_RESET_BIT];
	assign o_pready = 1'b1;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ctrl_r <= CTRL_RST;
			cmd_r <= CMD_RST;
		end else if (wr_acc && i_pstrb[0]) begin
			if (addr_is(i_paddr, ADDR_CTRL)) begin
				ctrl_r <= i_pwdata[CTRL_W-1:0];
			end
			if (addr_is(i_paddr, ADDR_CMD)) begin
				cmd_r <= i_pwdata[CMD_W-1:0];
			end
		end
	end

	always_comb begin
		status_word = 32'h0;
		status_word[ST_IN_LSB +: LI_COUNT] = in_r;
		status_word[ST_AUX1_BIT] = key_r[0];
		status_word[ST_AUX2_BIT] = key_r[1];
		status_word[ST_STOPKEY_BIT] = key_r[2];
		status_word[ST_RUN1_BIT] = run1_r;
		status_word[ST_RUN2_BIT] = run2_r;
		status_word[ST_FAULT_BIT] = fault_r;
		status_word[ST_WARN_BIT] = warn_r;
		status_word[ST_REMOTE_BIT] = in_r[LI_REMOTE];
		status_word[ST_LATCH1_BIT] = latch1_r;
		status_word[ST_LATCH2_BIT] = latch2_r;
	end

	// Read data is captured in the setup cycle so that a zero-wait access phase sees it
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
		end else if (i_psel && !i_penable) begin
			pslverr_r <= ~addr_known(i_paddr);
			prdata_r <= 32'h0;
			if (rd_setup) begin
				if (addr_is(i_paddr, ADDR_CTRL)) begin
					prdata_r <= {26'h0, ctrl_r};
				end else if (addr_is(i_paddr, ADDR_CMD)) begin
					prdata_r <= {29'h0, cmd_r};
				end else if (addr_is(i_paddr, ADDR_STATUS)) begin
					prdata_r <= status_word;
				end else if (addr_is(i_paddr, ADDR_MEM)) begin
					prdata_r <= {31'h0, mem_r};
				end
			end
		end
	end

	assign o_prdata = prdata_r;
	assign o_pslverr = pslverr_r & i_psel & i_penable;
endmodule

// ==== core/motor_ctl_pkg.sv ====
// Constants shared by the motor start/stop and fault logic and its bench.
// Assumes an APB master with 32-bit data; every register is one aligned word.
package motor_ctl_pkg;
	localparam int APB_AW = 8;
	localparam int LI_COUNT = 6;

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_MEM = 8'h0c;

	// Control register fields
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_WIRE3_BIT = 1;
	localparam int CTRL_STOPEN_BIT = 2;
	localparam int CTRL_DIAGEN_BIT = 3;
	localparam int CTRL_HMI_BIT = 4;
	localparam int CTRL_I3MEM_BIT = 5;
	localparam int CTRL_W = 6;
	localparam logic [5:0] CTRL_RST = 6'h04;

	// Command word fields
	localparam int CMD_FWD_BIT = 0;
	localparam int CMD_OUT23_BIT = 1;
	localparam int CMD_WARN_BIT = 2;
	localparam int CMD_RESET_BIT = 3;
	localparam int CMD_W = 3;
	localparam logic [2:0] CMD_RST = 3'h0;

	// Status word fields
	localparam int ST_IN_LSB = 0;
	localparam int ST_AUX1_BIT = 6;
	localparam int ST_AUX2_BIT = 7;
	localparam int ST_STOPKEY_BIT = 8;
	localparam int ST_RUN1_BIT = 9;
	localparam int ST_RUN2_BIT = 10;
	localparam int ST_FAULT_BIT = 11;
	localparam int ST_WARN_BIT = 12;
	localparam int ST_REMOTE_BIT = 13;
	localparam int ST_LATCH1_BIT = 14;
	localparam int ST_LATCH2_BIT = 15;

	// Logic input positions
	localparam int LI_START1 = 0;
	localparam int LI_START2 = 1;
	localparam int LI_FREE3 = 2;
	localparam int LI_STOP = 3;
	localparam int LI_RESET = 4;
	localparam int LI_REMOTE = 5;

	typedef enum logic {MODE_OVERLOAD, MODE_INDEPENDENT} mode_t;
	typedef enum logic [1:0] {CH_TERMINAL, CH_HMI, CH_NETWORK} channel_t;
endpackage

// ==== testbench/motor_ctl_sva.sv ====
// Checker for the motor start/stop and fault logic, bound to its top module.
// Assumes field inputs are levels synchronous to i_clk; mode is tracked from APB writes.
`timescale 1ns/100ps
module motor_ctl_sva
	import motor_ctl_pkg::*;
(
	// Clock, reset and APB
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	input wire logic o_pready,
	// Field side
	input wire logic [5:0] i_logic_in,
	input wire logic i_fault_det,
	input wire logic i_diag_err,
	input wire logic i_ctrl_volt_low,
	input wire logic o_run1,
	input wire logic o_run2,
	input wire logic o_warn,
	input wire logic o_fault_relay
);
	logic [5:0] ctrl_r;
	logic [2:0] cmd_r;
	logic wr;
	logic indep;
	assign wr = i_psel && i_penable && i_pwrite && i_pstrb[0] && o_pready;
	assign indep = ctrl_r[CTRL_MODE_BIT];
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ctrl_r <= CTRL_RST;
			cmd_r <= CMD_RST;
		end else if (wr && i_paddr == ADDR_CTRL) begin
			ctrl_r <= i_pwdata[5:0];
		end else if (wr && i_paddr == ADDR_CMD) begin
			cmd_r <= i_pwdata[2:0];
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	//////////////////////////////////////////////////////////////////////////////
	sequence s_two_wire;
		(indep && !ctrl_r[CTRL_WIRE3_BIT] && !ctrl_r[CTRL_HMI_BIT] && $stable(ctrl_r) && !i_logic_in[LI_REMOTE]
			&& $stable(i_logic_in[1:0]) && !i_ctrl_volt_low && !i_diag_err)[*2];
	endsequence
	sequence s_clean;
		(!i_fault_det && !i_ctrl_volt_low && !i_diag_err)[*3];
	endsequence
	property p_fault; i_fault_det |=> !o_fault_relay; endproperty
	a_fault: assert property (p_fault) else $error("fault relay stayed closed");
	property p_volt; (indep && i_ctrl_volt_low)[*2] |=> !o_run1 && !o_run2; endproperty
	a_volt: assert property (p_volt) else $error("run output on at low supply");
	property p_diag; (indep && i_diag_err)[*2] |=> !o_run1 && !o_fault_relay; endproperty
	a_diag: assert property (p_diag) else $error("diag error left output closed");
	property p_ovl_run;
		(!indep && $stable(cmd_r) && !i_ctrl_volt_low && !i_diag_err)[*3]
			|-> o_run1 == cmd_r[CMD_FWD_BIT] && o_run2 == cmd_r[CMD_OUT23_BIT];
	endproperty
	a_ovl_run: assert property (p_ovl_run) else $error("run outputs not following command");
	property p_ovl_warn; (!indep && $stable(cmd_r))[*3] |-> o_warn == cmd_r[CMD_WARN_BIT]; endproperty
	a_ovl_warn: assert property (p_ovl_warn) else $error("warning output managed in overload");
	property p_stop;
		(indep && ctrl_r[CTRL_WIRE3_BIT] && ctrl_r[CTRL_STOPEN_BIT] && !ctrl_r[CTRL_HMI_BIT]
			&& !i_logic_in[LI_REMOTE] && !i_logic_in[LI_STOP])[*2] |=> !o_run1 && !o_run2;
	endproperty
	a_stop: assert property (p_stop) else $error("run output closed without stop");
	property p_two_wire; s_two_wire |=> {o_run2, o_run1} == $past(i_logic_in[1:0]); endproperty
	a_two_wire: assert property (p_two_wire) else $error("run outputs not following inputs");
	property p_reset; $rose(i_logic_in[LI_RESET]) ##0 s_clean |-> o_fault_relay; endproperty
	a_reset: assert property (p_reset) else $error("fault relay not closed by reset");
endmodule
bind motor_ctl motor_ctl_sva chk (
	.i_clk(i_clk),
	.i_srst(i_srst),
	.i_psel(i_psel),
	.i_penable(i_penable),
	.i_pwrite(i_pwrite),
	.i_paddr(i_paddr),
	.i_pwdata(i_pwdata),
	.i_pstrb(i_pstrb),
	.o_pready(o_pready),
	.i_logic_in(i_logic_in),
	.i_fault_det(i_fault_det),
	.i_diag_err(i_diag_err),
	.i_ctrl_volt_low(i_ctrl_volt_low),
	.o_run1(o_run1),
	.o_run2(o_run2),
	.o_warn(o_warn),
	.o_fault_relay(o_fault_relay)
);

// ==== testbench/field_wiring.sv ====
// Field wiring model: stop pushbutton in series with the fault relay contact.
// Assumes the bench moves the pushbutton right after a rising clock edge.
`timescale 1ns/100ps
module field_wiring (
	// Clock
	input wire logic i_clk,
	// Operator and relay contact
	input wire logic i_stop_pb,
	input wire logic i_fault_contact,
	// Current at the stop input
	output logic o_stop_in
);
	// One cycle of contact travel delays the stop input; the relay output is already registered in motor_ctl
	always_ff @(posedge i_clk) begin
		o_stop_in <= i_stop_pb && i_fault_contact;
	end
endmodule

// ==== testbench/motor_ctl_tb.sv ====
// Self-checking bench for the motor start/stop and fault logic.
// Assumes the field wiring model feeds the stop input and an APB master reaches the registers.
`timescale 1ns/100ps
module motor_ctl_tb;
	import motor_ctl_pkg::*;
	logic i_clk, i_srst, psel, penable, pwrite, fault, diag, vlow, stop_pb, stop_in, e, warnd;
	logic pready, pslverr, run1, run2, warn, frelay;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [5:0] li;
	logic [2:0] keys;
	int err_total, compares;
	motor_ctl uut (.i_clk(i_clk), .i_srst(i_srst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready), .o_prdata(prdata),
		.o_pslverr(pslverr), .i_logic_in({li[5:4], stop_in, li[2:0]}), .i_key_aux1(keys[0]),
		.i_key_aux2(keys[1]), .i_key_stop(keys[2]), .i_fault_det(fault), .i_diag_err(diag),
		.i_warn_det(warnd), .i_ctrl_volt_low(vlow), .o_run1(run1), .o_run2(run2), .o_warn(warn),
		.o_fault_relay(frelay));
	field_wiring fw (.i_clk(i_clk), .i_stop_pb(stop_pb), .i_fault_contact(frelay), .o_stop_in(stop_in));
	//////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		compares++;
		if (g !== x) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic set(input logic [5:0] v, input int n);
		@(posedge i_clk) li <= v;
		step(n);
	endtask
	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		apb(0, ADDR_CTRL, 0);
		chk("ctrl", 32'h4, rd);
		apb(0, ADDR_CMD, 0);
		chk("cmd", 32'h0, rd);
		apb(0, 8'h10, 0);
		chk("slverr", 32'h1, e);
		chk("unmapped", 32'h0, rd);
	endtask
	task automatic t_overload;
		@(posedge i_clk) keys <= 3'h7;
		set(6'h07, 3);
		apb(0, ADDR_STATUS, 0);
		chk("status", 32'h1cf, rd & 32'h1ff);
		chk("run idle", 32'h0, {run2, run1});
		apb(1, ADDR_CMD, 32'h7);
		step(3);
		chk("ovl out", 32'h7, {warn, run2, run1});
		@(posedge i_clk) diag <= 1'b1;
		step(3);
		chk("diag off", 32'h1, frelay);
		apb(1, ADDR_CTRL, 32'hc);
		step(3);
		chk("diag on", 32'h0, frelay);
		@(posedge i_clk) diag <= 1'b0;
		keys <= 3'h0;
		set(6'h10, 3);
		chk("reset", 32'h1, frelay);
		// Reset input is still held high, so only the software reset can clear this fault
		@(posedge i_clk) fault <= 1'b1;
		@(posedge i_clk) fault <= 1'b0;
		step(2);
		chk("fault pulse", 32'h0, frelay);
		apb(1, ADDR_CMD, 32'h8);
		step(2);
		chk("sw reset", 32'h1, frelay);
		apb(1, ADDR_CMD, 32'h0);
	endtask
	task automatic t_two_wire;
		apb(1, ADDR_CTRL, 32'h01);
		set(6'h01, 3);
		chk("in1", 32'h1, {run2, run1});
		set(6'h02, 3);
		chk("in2", 32'h2, {run2, run1});
		set(6'h03, 3);
		chk("both", 32'h3, {run2, run1});
		@(posedge i_clk) warnd <= 1'b1;
		step(3);
		chk("warn", 32'h1, warn);
		@(posedge i_clk) warnd <= 1'b0;
		@(posedge i_clk) vlow <= 1'b1;
		step(3);
		chk("vlow", 32'h0, {run2, run1});
		@(posedge i_clk) vlow <= 1'b0;
		diag <= 1'b1;
		step(3);
		chk("diag", 32'h0, {frelay, run1});
		@(posedge i_clk) diag <= 1'b0;
		set(6'h10, 3);
		chk("reset", 32'h1, frelay);
		apb(1, ADDR_CTRL, 32'h21);
		set(6'h04, 3);
		apb(0, ADDR_MEM, 0);
		chk("mem", 32'h1, rd & 32'h1);
		chk("free3", 32'h0, {run2, run1});
		apb(1, ADDR_CTRL, 32'h11);
		@(posedge i_clk) keys <= 3'h3;
		set(6'h00, 3);
		chk("hmi", 32'h3, {run2, run1});
		@(posedge i_clk) keys <= 3'h7;
		step(3);
		chk("hmi stop", 32'h0, {run2, run1});
		@(posedge i_clk) keys <= 3'h3;
		step(3);
		chk("hmi free", 32'h3, {run2, run1});
		@(posedge i_clk) keys <= 3'h0;
		set(6'h20, 1);
		apb(1, ADDR_CMD, 32'h3);
		step(3);
		chk("remote", 32'h3, {run2, run1});
		apb(1, ADDR_CMD, 32'h0);
		set(6'h00, 3);
		apb(1, ADDR_MEM, 32'h1);
		apb(0, ADDR_MEM, 0);
		chk("mem clear", 32'h0, rd & 32'h1);
	endtask
	task automatic t_three_wire;
		apb(1, ADDR_CTRL, 32'h07);
		set(6'h01, 1);
		set(6'h00, 3);
		chk("latch1", 32'h1, run1);
		set(6'h02, 1);
		set(6'h00, 3);
		chk("latch2", 32'h3, {run2, run1});
		@(posedge i_clk) stop_pb <= 1'b0;
		step(4);
		chk("stop", 32'h0, {run2, run1});
		set(6'h01, 1);
		set(6'h00, 3);
		chk("no stop", 32'h0, run1);
		@(posedge i_clk) stop_pb <= 1'b1;
		step(3);
		chk("stay open", 32'h0, run1);
		set(6'h01, 1);
		set(6'h00, 3);
		@(posedge i_clk) fault <= 1'b1;
		step(6);
		chk("fault", 32'h0, {frelay, run1});
		@(posedge i_clk) fault <= 1'b0;
		set(6'h01, 1);
		set(6'h00, 4);
		chk("no restart", 32'h0, run1);
		set(6'h10, 4);
		chk("reset", 32'h1, frelay);
		@(posedge i_clk) fault <= 1'b1;
		@(posedge i_clk) fault <= 1'b0;
		step(6);
		chk("held reset", 32'h0, frelay);
		set(6'h00, 2);
		set(6'h10, 4);
		chk("new reset", 32'h1, frelay);
		set(6'h00, 3);
		chk("wait edge", 32'h0, run1);
		set(6'h01, 1);
		set(6'h00, 3);
		chk("restart", 32'h1, run1);
		apb(1, ADDR_CTRL, 32'h17);
		@(posedge i_clk) keys <= 3'h2;
		step(1);
		@(posedge i_clk) keys <= 3'h0;
		step(3);
		chk("hmi latch", 32'h3, {run2, run1});
		@(posedge i_clk) keys <= 3'h4;
		step(3);
		chk("hmi stop3", 32'h0, {run2, run1});
		@(posedge i_clk) keys <= 3'h0;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		#50000;
		err_total++;
		report_and_stop;
	end
	initial begin
		{i_srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
		{fault, diag, vlow, stop_pb, li, keys} = {4'h1, 9'h0};
		pstrb = 4'hf;
		warnd = 1'b0;
		err_total = 0;
		compares = 0;
		repeat (6) @(posedge i_clk);
		i_srst <= 1'b0;
		step(2);
		t_regs;
		t_overload;
		t_two_wire;
		t_three_wire;
		report_and_stop;
	end
endmodule
